// file: rtl/hpc_pkg.sv
package hpc_pkg;

	// Per-slot sequencing states.
	typedef enum logic [1:0] {
		ST_OFF,
		ST_UP,
		ST_ON,
		ST_DOWN
	} hpc_slot_e;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [3:0] OFS_CTRL     = 4'h0;
	localparam logic [3:0] OFS_STATUS   = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hc;

	// Field lanes; a lane holds one bit per slot, so its low bit sits at
	// lane times the slot count.
	localparam int LANE_LOCATE  = 0;
	localparam int LANE_ATTN    = 1;
	localparam int LANE_POWERED = 0;
	localparam int LANE_BUSY    = 1;
	localparam int LANE_FLT_IN  = 2;
	localparam int LANE_EV_BTN  = 0;
	localparam int LANE_EV_FLT  = 1;
	localparam int LANE_EV_DONE = 2;

	// Reset values.
	localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_STAT = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

	// Blink timing: 1 Hz, half period on and half off.
	localparam int CLK_HZ        = 50_000_000;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

	// Slots with hot-plug support: two behind each of two expanders.
	localparam int HP_SLOTS = 4;

endpackage

// file: rtl/hpc_slot_ctrl.sv
`timescale 1ns/1ns
// How it works
// - The green power LED goes dark only after every main rail of the slot reads as removed.
// - The green power LED is steadily lit while the slot is powered.
// - The green power LED blinks for the whole power-up or power-down transition.
// - The amber attention LED is off normally and steadily lit on a power fault or a software-flagged problem.
// - The amber attention LED blinks while a software locate request for the slot is active and no fault event or software flag holds it steadily lit.
// - An attention button press starts a hot-plug sequence by itself, with no software involved.
// - Each slot switches its 12 V, 3.3 V and aux 3.3 V rails on its own and reports a fault on current limit or voltage trip.
// - A slot can be powered down or up while all other slots and the bus interface keep running.
// - Slot sequencing follows the native serial-bus hot-plug model: button, blinking transition, power LED, attention LED.
// - Four slots carry hot-plug button, LEDs and power control; no others do.
module hpc_slot_ctrl #(
	parameter int N_SLOTS   = hpc_pkg::HP_SLOTS,
	parameter int HALF_CYC  = hpc_pkg::BLINK_HALF_CYC
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	input  wire logic [3:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [3:0]         avs_byteenable,
	input  wire logic [31:0]        avs_writedata,
	output logic      [31:0]        avs_readdata,
	output logic                    avs_waitrequest,
	output logic                    irq,
	input  wire logic [N_SLOTS-1:0] attn_btn,
	input  wire logic [N_SLOTS-1:0] cur_limit,
	input  wire logic [N_SLOTS-1:0] volt_fail,
	input  wire logic [N_SLOTS-1:0] good_12v,
	input  wire logic [N_SLOTS-1:0] good_3v3,
	input  wire logic [N_SLOTS-1:0] good_aux,
	output logic      [N_SLOTS-1:0] en_12v,
	output logic      [N_SLOTS-1:0] en_3v3,
	output logic      [N_SLOTS-1:0] en_aux,
	output logic      [N_SLOTS-1:0] power_led,
	output logic      [N_SLOTS-1:0] attn_led
);

	localparam int CW = $clog2(HALF_CYC);
	localparam int LW = 3 * N_SLOTS;

	hpc_pkg::hpc_slot_e         st_ff [N_SLOTS];
	hpc_pkg::hpc_slot_e         nxt_st [N_SLOTS];
	logic [CW-1:0]              blink_cnt_ff;
	logic                       blink_ff;
	logic [N_SLOTS-1:0]         btn_q_ff;
	logic [N_SLOTS-1:0]         press;
	logic [N_SLOTS-1:0]         fault;
	logic [N_SLOTS-1:0]         rails_up;
	logic [N_SLOTS-1:0]         rails_down;
	logic [N_SLOTS-1:0]         done;
	logic [N_SLOTS-1:0]         locate_ff;
	logic [N_SLOTS-1:0]         attn_sw_ff;
	logic [LW-1:0]              irq_stat_ff;
	logic [LW-1:0]              irq_mask_ff;
	logic [LW-1:0]              nxt_irq_stat;
	logic [LW-1:0]              ev_set;
	logic [LW-1:0]              ev_clr;
	logic [31:0]                wmask;
	logic [31:0]                be_bits;
	logic [31:0]                nxt_rdata;
	logic                       wr_go;
	logic [N_SLOTS-1:0]         powered;
	logic [N_SLOTS-1:0]         busy;
	logic [N_SLOTS-1:0]         flt_ev;

	// Byte enables widened to a bit mask.
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Field of one lane out of a word.
	function automatic logic [N_SLOTS-1:0] lane(input logic [31:0] w,
	                                           input int l);
		lane = N_SLOTS'(w >> (l * N_SLOTS));
	endfunction

	assign be_bits = be_mask(avs_byteenable);
	assign wmask  = be_bits & avs_writedata;
	assign wr_go  = avs_write && !avs_waitrequest;
	assign press  = attn_btn & ~btn_q_ff;
	assign fault  = cur_limit | volt_fail;
	assign rails_up   = good_12v & good_3v3 & good_aux;
	assign rails_down = ~(good_12v | good_3v3 | good_aux);
	assign flt_ev = irq_stat_ff[hpc_pkg::LANE_EV_FLT*N_SLOTS +: N_SLOTS];

	// Free-running divider; the phase flips every half period.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			blink_cnt_ff <= '0;
			blink_ff     <= 1'b0;
		end else if (blink_cnt_ff == CW'(HALF_CYC - 1)) begin
			blink_cnt_ff <= '0;
			blink_ff     <= ~blink_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			btn_q_ff <= '0;
		end else begin
			btn_q_ff <= attn_btn;
		end
	end

	// Each slot sequences on its own; the others are untouched.
	always_comb begin
		for (int i = 0; i < N_SLOTS; i++) begin
			nxt_st[i] = st_ff[i];
			done[i]   = 1'b0;
			case (st_ff[i])
				hpc_pkg::ST_OFF: begin
					if (press[i]) begin
						nxt_st[i] = hpc_pkg::ST_UP;
					end
				end
				hpc_pkg::ST_UP: begin
					if (fault[i]) begin
						nxt_st[i] = hpc_pkg::ST_DOWN;
					end else if (rails_up[i]) begin
						nxt_st[i] = hpc_pkg::ST_ON;
						done[i]   = 1'b1;
					end
				end
				hpc_pkg::ST_ON: begin
					if (fault[i] || press[i]) begin
						nxt_st[i] = hpc_pkg::ST_DOWN;
					end
				end
				hpc_pkg::ST_DOWN: begin
					if (rails_down[i]) begin
						nxt_st[i] = hpc_pkg::ST_OFF;
						done[i]   = 1'b1;
					end
				end
				default: begin
					nxt_st[i] = hpc_pkg::ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < N_SLOTS; i++) begin
				st_ff[i] <= hpc_pkg::ST_OFF;
			end
		end else begin
			for (int i = 0; i < N_SLOTS; i++) begin
				st_ff[i] <= nxt_st[i];
			end
		end
	end

	// Rails and LEDs, all registered.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_12v    <= '0;
			en_3v3    <= '0;
			en_aux    <= '0;
			power_led <= '0;
			attn_led  <= '0;
		end else begin
			for (int i = 0; i < N_SLOTS; i++) begin
				en_12v[i] <= powered[i] || st_ff[i] == hpc_pkg::ST_UP;
				en_3v3[i] <= powered[i] || st_ff[i] == hpc_pkg::ST_UP;
				en_aux[i] <= powered[i] || st_ff[i] == hpc_pkg::ST_UP;
				power_led[i] <= powered[i] || (busy[i] && blink_ff);
				if (flt_ev[i] || attn_sw_ff[i]) begin
					attn_led[i] <= 1'b1;
				end else begin
					attn_led[i] <= locate_ff[i] && blink_ff;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N_SLOTS; i++) begin
			powered[i] = st_ff[i] == hpc_pkg::ST_ON;
			busy[i]    = st_ff[i] == hpc_pkg::ST_UP ||
			             st_ff[i] == hpc_pkg::ST_DOWN;
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle.
	always_comb begin
		ev_set = '0;
		ev_set[hpc_pkg::LANE_EV_BTN*N_SLOTS +: N_SLOTS]  = press;
		ev_set[hpc_pkg::LANE_EV_FLT*N_SLOTS +: N_SLOTS]  =
			fault & (powered | busy);
		ev_set[hpc_pkg::LANE_EV_DONE*N_SLOTS +: N_SLOTS] = done;
		ev_clr = '0;
		if (wr_go && avs_address == hpc_pkg::OFS_IRQ_STAT) begin
			ev_clr = wmask[LW-1:0];
		end
		nxt_irq_stat = (irq_stat_ff & ~ev_clr) | ev_set;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat_ff <= hpc_pkg::RST_IRQ_STAT[LW-1:0];
			irq         <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq         <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// Software-writable control and mask; byte enables honoured.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			locate_ff   <= hpc_pkg::RST_CTRL[hpc_pkg::LANE_LOCATE*N_SLOTS +:
			                                 N_SLOTS];
			attn_sw_ff  <= hpc_pkg::RST_CTRL[hpc_pkg::LANE_ATTN*N_SLOTS +:
			                                 N_SLOTS];
			irq_mask_ff <= hpc_pkg::RST_IRQ_MASK[LW-1:0];
		end else if (wr_go) begin
			if (avs_address == hpc_pkg::OFS_CTRL) begin
				locate_ff  <= lane(wmask, hpc_pkg::LANE_LOCATE) |
				              (locate_ff & ~lane(be_mask(avs_byteenable),
				                                 hpc_pkg::LANE_LOCATE));
				attn_sw_ff <= lane(wmask, hpc_pkg::LANE_ATTN) |
				              (attn_sw_ff & ~lane(be_mask(avs_byteenable),
				                                  hpc_pkg::LANE_ATTN));
			end
			if (avs_address == hpc_pkg::OFS_IRQ_MASK) begin
				irq_mask_ff <= wmask[LW-1:0] |
				               (irq_mask_ff & ~be_bits[LW-1:0]);
			end
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (avs_address)
			hpc_pkg::OFS_CTRL: begin
				nxt_rdata[hpc_pkg::LANE_LOCATE*N_SLOTS +: N_SLOTS] = locate_ff;
				nxt_rdata[hpc_pkg::LANE_ATTN*N_SLOTS +: N_SLOTS]   = attn_sw_ff;
			end
			hpc_pkg::OFS_STATUS: begin
				nxt_rdata[hpc_pkg::LANE_POWERED*N_SLOTS +: N_SLOTS] = powered;
				nxt_rdata[hpc_pkg::LANE_BUSY*N_SLOTS +: N_SLOTS]    = busy;
				nxt_rdata[hpc_pkg::LANE_FLT_IN*N_SLOTS +: N_SLOTS]  = fault;
			end
			hpc_pkg::OFS_IRQ_STAT: begin
				nxt_rdata[LW-1:0] = irq_stat_ff;
			end
			hpc_pkg::OFS_IRQ_MASK: begin
				nxt_rdata[LW-1:0] = irq_mask_ff;
			end
			default: begin
				nxt_rdata = 32'h0000_0000;
			end
		endcase
	end

	// One wait cycle per access: read data is loaded as waitrequest drops.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= nxt_rdata;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	generate
		for (genvar g = 0; g < N_SLOTS; g++) begin : g_chk
			property p_green_off;
				@(posedge ref_clk) disable iff (!rst_b)
				st_ff[g] == hpc_pkg::ST_DOWN && rails_down[g] |=>
					st_ff[g] == hpc_pkg::ST_OFF ##1 !power_led[g];
			endproperty
			a_green_off: assert property (p_green_off)
				else $error("power LED not dark after rails removed");

			property p_green_on;
				@(posedge ref_clk) disable iff (!rst_b)
				st_ff[g] == hpc_pkg::ST_ON |=> power_led[g];
			endproperty
			a_green_on: assert property (p_green_on)
				else $error("power LED not lit on powered slot");

			property p_green_blink;
				@(posedge ref_clk) disable iff (!rst_b)
				busy[g] |=> power_led[g] == $past(blink_ff);
			endproperty
			a_green_blink: assert property (p_green_blink)
				else $error("power LED not blinking in transition");

			property p_amber_fault;
				@(posedge ref_clk) disable iff (!rst_b)
				flt_ev[g] |=> attn_led[g];
			endproperty
			a_amber_fault: assert property (p_amber_fault)
				else $error("attention LED not lit on fault");

			property p_locate;
				@(posedge ref_clk) disable iff (!rst_b)
				locate_ff[g] && !flt_ev[g] && !attn_sw_ff[g] |=>
					attn_led[g] == $past(blink_ff);
			endproperty
			a_locate: assert property (p_locate)
				else $error("attention LED not blinking for locate");

			property p_press_up;
				@(posedge ref_clk) disable iff (!rst_b)
				st_ff[g] == hpc_pkg::ST_OFF && press[g] |=>
					st_ff[g] == hpc_pkg::ST_UP ##1 en_12v[g] && en_aux[g];
			endproperty
			a_press_up: assert property (p_press_up)
				else $error("button press did not apply power");

			property p_fault_trip;
				@(posedge ref_clk) disable iff (!rst_b)
				st_ff[g] == hpc_pkg::ST_ON && fault[g] |=>
					st_ff[g] == hpc_pkg::ST_DOWN && flt_ev[g]
					##1 !en_12v[g] && !en_3v3[g];
			endproperty
			a_fault_trip: assert property (p_fault_trip)
				else $error("fault did not remove power and flag");

			property p_press_down;
				@(posedge ref_clk) disable iff (!rst_b)
				st_ff[g] == hpc_pkg::ST_ON && press[g] |=>
					busy[g] ##1 !en_3v3[g];
			endproperty
			a_press_down: assert property (p_press_down)
				else $error("button press did not remove power");
		end
	endgenerate

	property p_blink_div;
		@(posedge ref_clk) disable iff (!rst_b)
		blink_cnt_ff == CW'(HALF_CYC - 1) |=> blink_ff != $past(blink_ff);
	endproperty
	a_blink_div: assert property (p_blink_div)
		else $error("blink phase did not flip at half period");

	c_power_up: cover property (@(posedge ref_clk) disable iff (!rst_b)
		st_ff[0] == hpc_pkg::ST_UP ##1 st_ff[0] == hpc_pkg::ST_ON);
	c_power_dn: cover property (@(posedge ref_clk) disable iff (!rst_b)
		st_ff[0] == hpc_pkg::ST_DOWN ##1 st_ff[0] == hpc_pkg::ST_OFF);
	c_fault: cover property (@(posedge ref_clk) disable iff (!rst_b)
		st_ff[1] == hpc_pkg::ST_ON && fault[1]);
	c_irq: cover property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(irq));

endmodule // hpc_slot_ctrl

// file: verification/hpc_slot_model.sv
`timescale 1ns/1ns
// Slot supplies: with all enables on, aux comes up 1 cycle, 3.3 V DLY/2 cycles and 12 V DLY cycles later, and on
// removal 12 V goes first and aux last, so a dark LED must wait for aux.
module hpc_slot_model #(
	parameter int N   = 4,
	parameter int DLY = 40
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic [N-1:0] en_12v,
	input  wire logic [N-1:0] en_3v3,
	input  wire logic [N-1:0] en_aux,
	input  wire logic [N-1:0] trip_cur,
	input  wire logic [N-1:0] trip_volt,
	output logic      [N-1:0] good_12v,
	output logic      [N-1:0] good_3v3,
	output logic      [N-1:0] good_aux,
	output logic      [N-1:0] cur_limit,
	output logic      [N-1:0] volt_fail
);
	logic [7:0] cnt_ff [N];

	always_ff @(posedge ref_clk or negedge rst_b) begin
		for (int i = 0; i < N; i++) begin
			if (!rst_b) begin
				cnt_ff[i] <= 8'h00;
			end else if (en_12v[i] && en_3v3[i] && en_aux[i]) begin
				if (cnt_ff[i] != 8'(DLY))
					cnt_ff[i] <= cnt_ff[i] + 8'h01;
			end else if (cnt_ff[i] != 8'h00) begin
				cnt_ff[i] <= cnt_ff[i] - 8'h01;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			good_12v[i] = (cnt_ff[i] == 8'(DLY));
			good_3v3[i] = (cnt_ff[i] >= 8'(DLY / 2));
			good_aux[i] = (cnt_ff[i] != 8'h00);
		end
	end

	assign cur_limit = trip_cur;
	assign volt_fail = trip_volt;
endmodule // hpc_slot_model

// file: verification/test_slot_hotplug_indicator_control.sv
`timescale 1ns/1ns
module test_slot_hotplug_indicator_control;
	localparam int HALF = 8;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, irq;
	logic [3:0]  attn_btn = 4'h0, trip_cur = 4'h0, trip_volt = 4'h0;
	logic [3:0]  cur_limit, volt_fail, good_12v, good_3v3, good_aux;
	logic [3:0]  en_12v, en_3v3, en_aux, power_led, attn_led;
	logic [3:0]  pl_hi, pl_lo, al_hi, al_lo;
	int          mismatches = 0, cmp_count = 0, cyc = 0, n;

	always #10 ref_clk = ~ref_clk;

	hpc_slot_ctrl #(.N_SLOTS(4), .HALF_CYC(HALF)) u_hpc_slot_ctrl (
		.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .attn_btn(attn_btn),
		.cur_limit(cur_limit), .volt_fail(volt_fail), .good_12v(good_12v),
		.good_3v3(good_3v3), .good_aux(good_aux), .en_12v(en_12v),
		.en_3v3(en_3v3), .en_aux(en_aux), .power_led(power_led),
		.attn_led(attn_led));

	hpc_slot_model #(.N(4), .DLY(40)) u_hpc_slot_model (
		.ref_clk(ref_clk), .rst_b(rst_b), .en_12v(en_12v), .en_3v3(en_3v3),
		.en_aux(en_aux), .trip_cur(trip_cur), .trip_volt(trip_volt),
		.good_12v(good_12v), .good_3v3(good_3v3), .good_aux(good_aux),
		.cur_limit(cur_limit), .volt_fail(volt_fail));

	task automatic chk(input string nm, input logic [31:0] seen,
	                   input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end

	// Hold the request until waitrequest is sampled low, then release.
	task automatic bus(input logic wr, input logic [3:0] a,
	                   input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic observe(input int cycles);
		{pl_hi, pl_lo, al_hi, al_lo} = 16'h0;
		repeat (cycles) begin
			@(posedge ref_clk);
			pl_hi |= power_led;
			pl_lo |= ~power_led;
			al_hi |= attn_led;
			al_lo |= ~attn_led;
		end
	endtask

	task automatic press(input int s);
		@(posedge ref_clk);
		attn_btn[s] <= 1'b1;
		@(posedge ref_clk);
		attn_btn[s] <= 1'b0;
		repeat (3) @(posedge ref_clk);
		observe(20);
		chk("transition blink", {pl_hi[s], pl_lo[s]}, 32'h3);
	endtask

	task automatic power_up(input int s);
		press(s);
		chk("rails on", {en_12v[s], en_3v3[s], en_aux[s]}, 32'h7);
		repeat (40) @(posedge ref_clk);
		observe(20);
		chk("power steady", {pl_hi[s], pl_lo[s]}, 32'h2);
		chk("other slots", pl_hi & ~(4'h1 << s), 32'h0);
	endtask

	task automatic scn_reset;
		chk("reset rails", {en_12v, en_3v3, en_aux}, 32'h0);
		chk("reset leds", {power_led, attn_led}, 32'h0);
		bus(1'b0, hpc_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", rd, hpc_pkg::RST_CTRL);
		bus(1'b0, hpc_pkg::OFS_IRQ_STAT, 32'h0);
		chk("irq stat", rd, hpc_pkg::RST_IRQ_STAT);
		bus(1'b0, hpc_pkg::OFS_IRQ_MASK, 32'h0);
		chk("irq mask", rd, hpc_pkg::RST_IRQ_MASK);
		bus(1'b1, 4'h2, 32'hffff_ffff);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b0, hpc_pkg::OFS_CTRL, 32'h0);
		chk("ctrl kept", rd, 32'h0);
	endtask

	task automatic scn_up_down;
		power_up(0);
		bus(1'b0, hpc_pkg::OFS_STATUS, 32'h0);
		chk("status on", rd, 32'h1);
		bus(1'b0, hpc_pkg::OFS_IRQ_STAT, 32'h0);
		chk("events", rd, 32'h101);
		bus(1'b1, hpc_pkg::OFS_IRQ_STAT, 32'h101);
		bus(1'b0, hpc_pkg::OFS_IRQ_STAT, 32'h0);
		chk("events cleared", rd, 32'h0);
		press(0);
		bus(1'b0, hpc_pkg::OFS_STATUS, 32'h0);
		chk("status busy", rd, 32'h10);
		repeat (40) @(posedge ref_clk);
		observe(20);
		chk("dark", {pl_hi[0], good_12v[0], good_3v3[0], good_aux[0]}, 0);
		bus(1'b0, hpc_pkg::OFS_IRQ_STAT, 32'h0);
		chk("down events", rd, 32'h101);
		bus(1'b1, hpc_pkg::OFS_IRQ_STAT, 32'h101);
	endtask

	task automatic fault_case(input int s, input logic volt);
		logic [31:0] ev;
		ev = (32'h1 << s) | (32'h10 << s) | (32'h100 << s);
		power_up(s);
		bus(1'b1, hpc_pkg::OFS_IRQ_MASK, 32'h10 << s);
		@(posedge ref_clk);
		trip_volt[s] <= volt;
		trip_cur[s] <= ~volt;
		repeat (4) @(posedge ref_clk);
		trip_volt[s] <= 1'b0;
		trip_cur[s] <= 1'b0;
		repeat (60) @(posedge ref_clk);
		observe(20);
		chk("fault rails", {en_12v[s], en_3v3[s], en_aux[s]}, 32'h0);
		chk("fault amber", {al_hi[s], al_lo[s]}, 32'h2);
		chk("irq raised", irq, 32'h1);
		bus(1'b0, hpc_pkg::OFS_IRQ_STAT, 32'h0);
		chk("fault events", rd, ev);
		bus(1'b1, hpc_pkg::OFS_IRQ_STAT, ev);
		repeat (3) @(posedge ref_clk);
		chk("irq cleared", irq, 32'h0);
		chk("amber cleared", attn_led[s], 32'h0);
	endtask

	task automatic scn_locate;
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'h4);
		repeat (2) @(posedge ref_clk);
		observe(20);
		chk("locate blink", {al_hi[2], al_lo[2]}, 32'h3);
		chk("amber others", al_hi & 4'hb, 32'h0);
		do @(posedge ref_clk); while (attn_led[2] !== 1'b0);
		do @(posedge ref_clk); while (attn_led[2] !== 1'b1);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (attn_led[2] === 1'b1);
		chk("blink half", n, HALF);
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'h44);
		bus(1'b0, hpc_pkg::OFS_CTRL, 32'h0);
		chk("ctrl rw", rd, 32'h44);
		observe(20);
		chk("attention steady", {al_hi[2], al_lo[2]}, 32'h2);
		bus(1'b1, hpc_pkg::OFS_CTRL, 32'h0);
		repeat (2) @(posedge ref_clk);
		observe(10);
		chk("amber off", al_hi, 32'h0);
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		scn_reset();
		scn_up_down();
		fault_case(1, 1'b0);
		fault_case(2, 1'b1);
		scn_locate();
		close_out();
	end
endmodule // test_slot_hotplug_indicator_control
